/* File: sdp_pkg.sv */
// Overview of operation
// - Prescaler divides RF input by 10 or 11.
// - Bypass high: RF feeds main counter directly.
// - Main chain divides by 10(M+1)+A.
// - Bypassed, main value one gives division by two.
// - Bypassed chain divides by main value plus one.
// - Reference counter divides by value plus one.
// - Reference value zero passes input undivided.
// - Mode pins pick direct, parallel or serial.
// - Direct mode: pins drive counters, tops zero.
// - Parallel high and mid strobes load sections.
// - Swallow strobe loads low; hop copies word.
// - Parallel bank select picks primary or secondary.
// - Option strobe latches bus; enable low gates.
// - Serial shifts twenty bits, first bit first.
// - Serial load or hop copies primary over.
// - Serial bank select picks primary or secondary.
// - Option strobe high shifts eight option bits.
// - Option shift captured on option strobe fall.
// - Captured options act only while enable low.
// - Option bits: power, load, two tests, disable.
// - Power down stops counters; load applies continuously.
// - Test output routing; disable kills divider outputs.
package sdp_pkg;

  // ==========================================================
  // Widths
  localparam int WORD_W = 20;
  localparam int OPT_W  = 8;
  localparam int MAIN_W = 9;
  localparam int REF_W  = 6;
  localparam int SWAL_W = 4;
  localparam int PRE_W  = 4;

  // ==========================================================
  // Frequency word field positions
  localparam int REF_HI_POS  = 18;
  localparam int MAIN_HI_POS = 16;
  localparam int BYPASS_POS  = 15;
  localparam int MAIN_LO_POS = 8;
  localparam int REF_LO_POS  = 4;
  localparam int SWAL_POS    = 0;

  // Parallel load sections
  localparam int HIGH_SEC_POS = 16;
  localparam int HIGH_SEC_W   = 4;
  localparam int MID_SEC_POS  = 8;
  localparam int LOW_SEC_POS  = 0;

  // ==========================================================
  // Option bits
  localparam int OPT_DISABLE_BIT  = 0;
  localparam int OPT_PRE_OUT_BIT  = 1;
  localparam int OPT_MODULUS_SELECT_OUT_BIT = 2;
  localparam int OPT_LOAD_BIT     = 3;
  localparam int OPT_PDOWN_BIT    = 4;

  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 20'h0_0000;
  localparam logic [OPT_W-1:0]  OPT_RESET  = 8'h00;

  // Prescaler moduli
  localparam logic [PRE_W-1:0] PRE_DIV_LOW  = 4'hA;
  localparam logic [PRE_W-1:0] PRE_DIV_HIGH = 4'hB;

  // ==========================================================
  // Interface modes
  typedef enum logic [2:0] {
    SDP_MODE_PARALLEL = 3'b001,
    SDP_MODE_SERIAL   = 3'b010,
    SDP_MODE_DIRECT   = 3'b100
  } sdp_mode_type;

endpackage

/* File: sdp_core.sv */
`timescale 1ns/1ps
module sdp_core (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // Mode pins
  input  wire logic                       interface_type,
  input  wire logic                       serial_select,
  input  wire logic                       option_enable_n,
  // Parallel port
  input  wire logic [sdp_pkg::OPT_W-1:0]  bus_data,
  input  wire logic                       high_section_strobe,
  input  wire logic                       mid_section_strobe,
  input  wire logic                       swallow_strobe,
  input  wire logic                       hop_strobe,
  input  wire logic                       option_strobe,
  // Serial port
  input  wire logic                       serial_clk,
  input  wire logic                       serial_data,
  input  wire logic                       serial_load_strobe,
  // Bank selects
  input  wire logic                       parallel_bank_select,
  input  wire logic                       serial_bank_select,
  // Direct pins
  input  wire logic                       direct_bypass,
  input  wire logic [6:0]                 direct_main,
  input  wire logic [3:0]                 direct_ref,
  input  wire logic [3:0]                 direct_swallow,
  // Signal inputs
  input  wire logic                       rf_in,
  input  wire logic                       reference_input,
  // Outputs
  output logic                            main_divider_out,
  output logic                            comparison_out,
  output logic                            test_out,
  output logic                            modulus_select,
  output logic                            prescaler_power_down
);
  import sdp_pkg::*;

  // ==========================================================
  // Edge detection
  logic high_prev;
  logic mid_prev;
  logic swal_prev;
  logic hop_prev;
  logic opt_prev;
  logic sclk_prev;
  logic load_prev;
  logic rf_prev;
  logic refin_prev;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      high_prev  <= 1'b0;
      mid_prev   <= 1'b0;
      swal_prev  <= 1'b0;
      hop_prev   <= 1'b0;
      opt_prev   <= 1'b0;
      sclk_prev  <= 1'b0;
      load_prev  <= 1'b0;
      rf_prev    <= 1'b0;
      refin_prev <= 1'b0;
    end else begin
      high_prev  <= high_section_strobe;
      mid_prev   <= mid_section_strobe;
      swal_prev  <= swallow_strobe;
      hop_prev   <= hop_strobe;
      opt_prev   <= option_strobe;
      sclk_prev  <= serial_clk;
      load_prev  <= serial_load_strobe;
      rf_prev    <= rf_in;
      refin_prev <= reference_input;
    end
  end

  logic high_rise;
  logic mid_rise;
  logic swal_rise;
  logic hop_rise;
  logic opt_rise;
  logic opt_fall;
  logic sclk_rise;
  logic load_rise;
  logic rf_rise;
  logic ref_rise;

  assign high_rise = high_section_strobe & ~high_prev;
  assign mid_rise  = mid_section_strobe & ~mid_prev;
  assign swal_rise = swallow_strobe & ~swal_prev;
  assign hop_rise  = hop_strobe & ~hop_prev;
  assign opt_rise  = option_strobe & ~opt_prev;
  assign opt_fall  = ~option_strobe & opt_prev;
  assign sclk_rise = serial_clk & ~sclk_prev;
  assign load_rise = serial_load_strobe & ~load_prev;
  assign rf_rise   = rf_in & ~rf_prev;
  assign ref_rise  = reference_input & ~refin_prev;

  // ==========================================================
  // Interface mode
  sdp_mode_type mode;

  always_comb begin
    if (interface_type) begin
      mode = SDP_MODE_DIRECT;
    end else if (serial_select) begin
      mode = SDP_MODE_SERIAL;
    end else begin
      mode = SDP_MODE_PARALLEL;
    end
  end

  // ==========================================================
  // Programming registers
  logic [WORD_W-1:0] frequency_word_staging;
  logic [WORD_W-1:0] frequency_word_hop_buffer;
  logic [OPT_W-1:0]  option_shift;
  logic [OPT_W-1:0]  option_control_latch;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frequency_word_staging <= WORD_RESET;
    end else begin
      case (mode)
        SDP_MODE_PARALLEL: begin
          if (high_rise) begin
            frequency_word_staging[HIGH_SEC_POS +: HIGH_SEC_W] <= bus_data[3:0];
          end
          if (mid_rise) begin
            frequency_word_staging[MID_SEC_POS +: OPT_W] <= bus_data;
          end
          if (swal_rise) begin
            frequency_word_staging[LOW_SEC_POS +: OPT_W] <= bus_data;
          end
        end
        SDP_MODE_SERIAL: begin
          if (sclk_rise && !option_strobe && !serial_load_strobe) begin
            frequency_word_staging <= {frequency_word_staging[WORD_W-2:0], serial_data};
          end
        end
        default: begin
          frequency_word_staging <= frequency_word_staging;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frequency_word_hop_buffer <= WORD_RESET;
    end else begin
      case (mode)
        SDP_MODE_PARALLEL: begin
          if (hop_rise) begin
            frequency_word_hop_buffer <= frequency_word_staging;
          end
        end
        SDP_MODE_SERIAL: begin
          if (load_rise || hop_rise) begin
            frequency_word_hop_buffer <= frequency_word_staging;
          end
        end
        default: begin
          frequency_word_hop_buffer <= frequency_word_hop_buffer;
        end
      endcase
    end
  end

  // Shadow stage keeps controls steady while bits stream in
  always_ff @(posedge core_clk) begin
    if (srst) begin
      option_shift <= OPT_RESET;
    end else if (mode == SDP_MODE_SERIAL && sclk_rise && option_strobe
                 && !serial_load_strobe) begin
      option_shift <= {option_shift[OPT_W-2:0], serial_data};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      option_control_latch <= OPT_RESET;
    end else begin
      case (mode)
        SDP_MODE_PARALLEL: begin
          if (opt_rise) begin
            option_control_latch <= bus_data;
          end
        end
        SDP_MODE_SERIAL: begin
          if (opt_fall) begin
            option_control_latch <= option_shift;
          end
        end
        default: begin
          option_control_latch <= option_control_latch;
        end
      endcase
    end
  end

  // ==========================================================
  // Active word and options
  logic [WORD_W-1:0] active_word;
  logic [OPT_W-1:0]  opt_eff;

  always_comb begin
    active_word = WORD_RESET;
    case (mode)
      SDP_MODE_DIRECT: begin
        active_word[BYPASS_POS]         = direct_bypass;
        active_word[MAIN_LO_POS +: 7]   = direct_main;
        active_word[REF_LO_POS +: 4]    = direct_ref;
        active_word[SWAL_POS +: SWAL_W] = direct_swallow;
      end
      SDP_MODE_PARALLEL: begin
        active_word = parallel_bank_select ? frequency_word_staging
                                           : frequency_word_hop_buffer;
      end
      SDP_MODE_SERIAL: begin
        active_word = serial_bank_select ? frequency_word_staging
                                         : frequency_word_hop_buffer;
      end
      default: begin
        active_word = frequency_word_staging;
      end
    endcase
  end

  // Reserved bits are carried but never read
  assign opt_eff = option_enable_n ? OPT_RESET : option_control_latch;

  logic power_down;
  logic counter_load;

  assign power_down   = opt_eff[OPT_PDOWN_BIT];
  assign counter_load = opt_eff[OPT_LOAD_BIT];

  logic [MAIN_W-1:0] act_main;
  logic [REF_W-1:0]  act_ref;

  assign act_main = {active_word[MAIN_HI_POS +: 2], active_word[MAIN_LO_POS +: 7]};
  assign act_ref  = {active_word[REF_HI_POS +: 2], active_word[REF_LO_POS +: 4]};

  // ==========================================================
  // Working counter settings
  logic [MAIN_W-1:0] work_main;
  logic [SWAL_W-1:0] work_swal;
  logic              work_bypass;
  logic [REF_W-1:0]  work_ref;
  logic              main_wrap;
  logic              ref_wrap;

  // Without counter load or power down, new values land only at a cycle boundary
  always_ff @(posedge core_clk) begin
    if (srst) begin
      work_main   <= WORD_RESET[MAIN_LO_POS +: MAIN_W];
      work_swal   <= WORD_RESET[SWAL_POS +: SWAL_W];
      work_bypass <= WORD_RESET[BYPASS_POS];
    end else if (counter_load || power_down || main_wrap) begin
      work_main   <= act_main;
      work_swal   <= active_word[SWAL_POS +: SWAL_W];
      work_bypass <= active_word[BYPASS_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      work_ref <= WORD_RESET[REF_LO_POS +: REF_W];
    end else if (counter_load || power_down || ref_wrap) begin
      work_ref <= act_ref;
    end
  end

  // ==========================================================
  // Main counter chain
  logic [PRE_W-1:0]  pre_cnt;
  logic [PRE_W-1:0]  pre_last;
  logic [MAIN_W-1:0] main_cnt;
  logic              modulus_select_now;
  logic              pre_tick;

  assign modulus_select_now  = !work_bypass && (main_cnt < {5'h00, work_swal});
  assign pre_last  = (modulus_select_now ? PRE_DIV_HIGH : PRE_DIV_LOW) - 4'h1;
  assign pre_tick  = work_bypass ? rf_rise : (rf_rise && pre_cnt == pre_last);
  assign main_wrap = !power_down && pre_tick && (main_cnt >= work_main);

  always_ff @(posedge core_clk) begin
    if (srst || power_down || work_bypass) begin
      pre_cnt <= 4'h0;
    end else if (rf_rise) begin
      pre_cnt <= (pre_cnt == pre_last) ? 4'h0 : pre_cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || power_down) begin
      main_cnt <= 9'h000;
    end else if (pre_tick) begin
      main_cnt <= main_wrap ? 9'h000 : main_cnt + 9'h001;
    end
  end

  // ==========================================================
  // Reference counter
  logic [REF_W-1:0] ref_cnt;

  assign ref_wrap = !power_down && ref_rise && (ref_cnt >= work_ref);

  always_ff @(posedge core_clk) begin
    if (srst || power_down) begin
      ref_cnt <= 6'h00;
    end else if (ref_rise) begin
      ref_cnt <= ref_wrap ? 6'h00 : ref_cnt + 6'h01;
    end
  end

  // ==========================================================
  // Outputs
  logic outputs_off;

  assign outputs_off = power_down || opt_eff[OPT_DISABLE_BIT];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      main_divider_out <= 1'b0;
      comparison_out   <= 1'b0;
    end else begin
      main_divider_out <= !outputs_off && main_wrap;
      comparison_out   <= !outputs_off && ((work_ref == 6'h00) ? reference_input
                                                               : ref_wrap);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      test_out             <= 1'b0;
      modulus_select       <= 1'b0;
      prescaler_power_down <= 1'b0;
    end else begin
      modulus_select       <= !power_down && modulus_select_now;
      prescaler_power_down <= power_down || work_bypass;
      if (opt_eff[OPT_MODULUS_SELECT_OUT_BIT]) begin
        test_out <= !power_down && modulus_select_now;
      end else if (opt_eff[OPT_PRE_OUT_BIT]) begin
        test_out <= !power_down && pre_tick;
      end else begin
        test_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  chk_direct_tops_zero: assert property (
    interface_type |-> (act_main[8:7] == 2'b00 && act_ref[5:4] == 2'b00))
    else $error("direct mode top bits not forced low");

  chk_bank_follow: assert property (
    (!interface_type && serial_select && serial_bank_select)
      |-> active_word == frequency_word_staging)
    else $error("serial bank select ignored");

  chk_high_load: assert property (
    (mode == SDP_MODE_PARALLEL && high_rise)
      |=> frequency_word_staging[19:16] == $past(bus_data[3:0]))
    else $error("high section not loaded");

  chk_swallow_load: assert property (
    (mode == SDP_MODE_PARALLEL && swal_rise)
      |=> frequency_word_staging[7:0] == $past(bus_data))
    else $error("swallow section not loaded");

  chk_hop_copy: assert property (
    (mode == SDP_MODE_SERIAL && load_rise)
      |=> frequency_word_hop_buffer == $past(frequency_word_staging))
    else $error("serial load did not copy primary");

  chk_serial_shift: assert property (
    (mode == SDP_MODE_SERIAL && sclk_rise && !option_strobe && !serial_load_strobe)
      |=> frequency_word_staging[0] == $past(serial_data)
          && frequency_word_staging[19:1] == $past(frequency_word_staging[18:0]))
    else $error("serial shift wrong");

  chk_option_steady: assert property (
    (mode == SDP_MODE_SERIAL && option_strobe && $past(option_strobe))
      |-> $stable(option_control_latch))
    else $error("options changed during shift");

  chk_option_capture: assert property (
    (mode == SDP_MODE_SERIAL && opt_fall)
      |=> option_control_latch == $past(option_shift))
    else $error("option capture missed");

  chk_option_gate: assert property (
    option_enable_n |=> !test_out)
    else $error("test output active with options off");

  chk_output_disable: assert property (
    opt_eff[OPT_DISABLE_BIT] |=> !main_divider_out && !comparison_out)
    else $error("divider outputs not disabled");

  chk_ref_pass: assert property (
    (work_ref == 6'h00 && !outputs_off) |=> comparison_out == $past(reference_input))
    else $error("reference not passed through");

  chk_prescale_eleven: assert property (
    (!work_bypass && modulus_select_now && rf_rise && pre_cnt == 4'h9 && !power_down)
      |=> pre_cnt == 4'hA)
    else $error("prescaler did not extend to eleven");

  cov_main_wrap: cover property (main_wrap && !work_bypass && work_swal != 4'h0);
  cov_bypass_wrap: cover property (main_wrap && work_bypass);
  cov_option_serial: cover property (mode == SDP_MODE_SERIAL && opt_fall);
  cov_hop_parallel: cover property (mode == SDP_MODE_PARALLEL && hop_rise);

endmodule

/* File: sdp_host.sv */
`timescale 1ns/1ps
module sdp_host (
  // Clock
  input  wire logic       core_clk,
  // Parallel port, strb: high, mid, swallow, hop, option, serial load
  output logic [7:0]      bus_data,
  output logic [5:0]      strb,
  // Serial port
  output logic            serial_clk,
  output logic            serial_data
);

  initial begin
    bus_data    = 8'h00;
    strb        = 6'h00;
    serial_clk  = 1'b0;
    serial_data = 1'b0;
  end

  // ==========================================================
  // Strobe pulse, two cycles high and two low
  task automatic pulse(input int sel, input logic [7:0] d);
    @(negedge core_clk);
    bus_data  = d;
    strb[sel] = 1'b1;
    repeat (2) @(negedge core_clk);
    strb[sel] = 1'b0;
    // Released bus must not keep showing the old byte
    bus_data  = ~d;
    repeat (2) @(negedge core_clk);
  endtask

  // ==========================================================
  // Serial frame, first bit first; clock idles low between frames
  task automatic shift(input logic [19:0] v, input int n, input bit opt);
    @(negedge core_clk);
    strb[4] = opt;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge core_clk);
      serial_data = v[i];
      serial_clk  = 1'b1;
      @(negedge core_clk);
      serial_clk  = 1'b0;
    end
    serial_data = ~serial_data;
    @(negedge core_clk);
  endtask

  // Option capture happens on this fall, so callers can look before it
  task automatic opt_release;
    @(negedge core_clk);
    strb[4] = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic       core_clk, srst, interface_type, serial_select, option_enable_n;
  logic       parallel_bank_select, serial_bank_select, direct_bypass;
  logic [6:0] direct_main;
  logic [3:0] direct_ref, direct_swallow;
  logic       rf_in, reference_input, serial_clk, serial_data;
  logic [7:0] bus_data;
  logic [5:0] strb;
  logic       main_divider_out, comparison_out, test_out, modulus_select;
  logic       prescaler_power_down;
  logic       prev_m = 1'b0;
  logic       prev_c = 1'b0;
  logic       prev_t = 1'b0;
  int         n_test = 0;
  int         n_main = 0;
  int         n_comp = 0;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cycles = 0;

  sdp_host u_sdp_host (.core_clk(core_clk), .bus_data(bus_data), .strb(strb),
    .serial_clk(serial_clk), .serial_data(serial_data));

  sdp_core u_sdp_core (.core_clk(core_clk), .srst(srst), .interface_type(interface_type),
    .serial_select(serial_select), .option_enable_n(option_enable_n),
    .bus_data(bus_data), .high_section_strobe(strb[0]), .mid_section_strobe(strb[1]),
    .swallow_strobe(strb[2]), .hop_strobe(strb[3]), .option_strobe(strb[4]),
    .serial_clk(serial_clk), .serial_data(serial_data), .serial_load_strobe(strb[5]),
    .parallel_bank_select(parallel_bank_select), .serial_bank_select(serial_bank_select),
    .direct_bypass(direct_bypass), .direct_main(direct_main), .direct_ref(direct_ref),
    .direct_swallow(direct_swallow), .rf_in(rf_in), .reference_input(reference_input),
    .main_divider_out(main_divider_out), .comparison_out(comparison_out),
    .test_out(test_out), .modulus_select(modulus_select),
    .prescaler_power_down(prescaler_power_down));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Output edge counters and hang guard
  always @(posedge core_clk) begin
    prev_m <= main_divider_out;
    prev_c <= comparison_out;
    prev_t <= test_out;
    if (test_out === 1'b1 && prev_t === 1'b0) n_test <= n_test + 1;
    if (main_divider_out === 1'b1 && prev_m === 1'b0) n_main <= n_main + 1;
    if (comparison_out === 1'b1 && prev_c === 1'b0) n_comp <= n_comp + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Signal inputs kept below half the core clock rate
  task automatic rise(input bit sel);
    @(negedge core_clk);
    rf_in           = !sel;
    reference_input = sel;
    repeat (2) @(negedge core_clk);
    rf_in           = 1'b0;
    reference_input = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // First wrap may still use old values, so the second gap is measured
  task automatic gap(input bit sel, input int exp);
    int c;
    int r;
    for (int k = 0; k < 2; k++) begin
      c = sel ? n_comp : n_main;
      r = 0;
      while ((sel ? n_comp : n_main) == c && r < 700) begin
        rise(sel);
        r++;
      end
    end
    chk(r, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_serial;
    serial_select      = 1'b1;
    serial_bank_select = 1'b1;
    u_sdp_host.shift(20'h0_8100, 20, 1'b0);
    gap(1'b0, 2);
    gap(1'b1, 1);
    chk(prescaler_power_down, 1);
    u_sdp_host.pulse(5, 8'h00);
    u_sdp_host.shift(20'h0_8400, 20, 1'b0);
    gap(1'b0, 5);
    serial_bank_select = 1'b0;
    gap(1'b0, 2);
  endtask

  task automatic t_parallel;
    serial_select        = 1'b0;
    parallel_bank_select = 1'b1;
    u_sdp_host.pulse(0, 8'h00);
    u_sdp_host.pulse(1, 8'h02);
    u_sdp_host.pulse(2, 8'h31);
    gap(1'b0, 31);
    gap(1'b1, 4);
    chk(prescaler_power_down, 0);
    u_sdp_host.pulse(3, 8'h00);
    u_sdp_host.pulse(0, 8'h04);
    u_sdp_host.pulse(1, 8'h81);
    gap(1'b0, 2);
    gap(1'b1, 20);
    parallel_bank_select = 1'b0;
    gap(1'b0, 31);
  endtask

  task automatic t_option;
    int c;
    option_enable_n = 1'b0;
    u_sdp_host.pulse(4, 8'h01);
    c = n_main;
    repeat (40) rise(1'b0);
    chk(n_main - c, 0);
    option_enable_n = 1'b1;
    gap(1'b0, 31);
    serial_select   = 1'b1;
    option_enable_n = 1'b0;
    u_sdp_host.shift(20'h0_0010, 8, 1'b1);
    chk(prescaler_power_down, 0);
    u_sdp_host.opt_release();
    chk(prescaler_power_down, 1);
    u_sdp_host.shift(20'h0_0000, 8, 1'b1);
    u_sdp_host.opt_release();
    gap(1'b0, 31);
  endtask

  // Test output routing and counter load, word M=2 A=1 in the hop buffer
  task automatic t_test;
    int k;
    int t;
    serial_bank_select = 1'b0;
    u_sdp_host.shift(20'h0_0004, 8, 1'b1);
    u_sdp_host.opt_release();
    gap(1'b0, 31);
    k = 0;
    t = 0;
    repeat (31) begin
      k += (modulus_select === 1'b1);
      t += (test_out === 1'b1);
      rise(1'b0);
    end
    chk(k, 11);
    chk(t, 11);
    u_sdp_host.shift(20'h0_0002, 8, 1'b1);
    u_sdp_host.opt_release();
    k = n_test;
    repeat (31) rise(1'b0);
    chk(n_test - k, 3);
    u_sdp_host.shift(20'h0_0008, 8, 1'b1);
    u_sdp_host.opt_release();
    repeat (5) rise(1'b0);
    // Staging holds bypass M=1; with counter load it applies mid-cycle
    serial_bank_select = 1'b1;
    k = n_main;
    t = 0;
    while (n_main == k && t < 40) begin
      rise(1'b0);
      t++;
    end
    chk(t, 2);
    option_enable_n = 1'b1;
  endtask

  task automatic t_direct;
    interface_type = 1'b1;
    direct_bypass  = 1'b1;
    direct_main    = 7'h03;
    direct_ref     = 4'h2;
    gap(1'b0, 4);
    gap(1'b1, 3);
  endtask

  task automatic results;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    srst                 = 1'b1;
    interface_type       = 1'b0;
    serial_select        = 1'b0;
    option_enable_n      = 1'b1;
    parallel_bank_select = 1'b1;
    serial_bank_select   = 1'b1;
    direct_bypass        = 1'b0;
    direct_main          = 7'h00;
    direct_ref           = 4'h0;
    direct_swallow       = 4'h0;
    rf_in                = 1'b0;
    reference_input      = 1'b0;
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    t_serial();
    t_parallel();
    t_option();
    t_test();
    t_direct();
    results();
  end
endmodule
